// ---- hdl/dma_channel_irq_event_control.sv ----
// Channel interrupt, event and standby control with its register port.
// Behaviour
// - Block completion sets channel done flag.
// - Bus error or bad descriptor sets fault.
// - Entering suspend sets channel halted flag.
// - Enable set/clear registers act on ones.
// - Both enable registers read same state.
// - Request is flag AND enable, per channel.
// - All channel requests ORed into one.
// - Readable summary, one bit per channel.
// - Lowest pending channel with its flags.
// - Output event on block or beat.
// - Output event only when output enabled.
// - Input event performs configured channel action.
// - Actions only when input enable set.
// - Events only on supported low channels.
// - Standby running only with run bit.
// - Wake on interrupt, act on events asleep.
// - Standby RAM access only without back bias.
// - Output event copies its source, one cycle late.
// - Cause 0x1 block, 0x3 beat.
`timescale 1ns/1ps
module dma_channel_irq_event_control (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        write_i,
    input  wire logic        read_i,
    output logic      [31:0] rdata_o,
    input  wire logic [15:0] block_done_i,
    input  wire logic [15:0] beat_done_i,
    input  wire logic [15:0] bus_error_i,
    input  wire logic [15:0] bad_descriptor_i,
    input  wire logic [15:0] suspend_enter_i,
    input  wire logic [3:0]  event_in_i,
    input  wire logic        standby_i,
    input  wire logic [3:0]  ram_back_bias_setting_i,
    output logic             irq_o,
    output logic             wake_o,
    output logic [3:0]       event_out_o,
    output logic [15:0]      channel_run_o,
    output logic             ram_access_ok_o,
    output logic [15:0]      transfer_start_action_o,
    output logic [15:0]      conditional_start_action_o,
    output logic [15:0]      conditional_block_action_o,
    output logic [15:0]      suspend_action_o,
    output logic [15:0]      resume_action_o,
    output logic [15:0]      bypass_next_pause_action_o,
    output logic [15:0]      raise_priority_action_o
);
    localparam int N = dma_irq_pkg::NUM_CH;
    localparam int E = dma_irq_pkg::NUM_EVT_CH;

    // Plain storage for the global registers; their datapaths live elsewhere.
    logic [15:0] global_control_q;
    logic [15:0] checksum_control_q;
    logic [31:0] checksum_data_input_q;
    logic [31:0] checksum_result_q;
    logic [7:0]  checksum_state_q;
    logic [7:0]  debug_halt_control_q;
    logic [7:0]  service_quality_control_q;
    logic [31:0] software_trigger_control_q;
    logic [31:0] priority_control_q;
    logic [3:0]  ch_sel_q;

    // Per-channel state.
    logic [2:0]  channel_irq_flags_q [N];
    logic [2:0]  irq_enable_q        [N];
    logic [7:0]  channel_control_first_q  [N];
    logic [7:0]  channel_control_second_q [N];
    logic [1:0]  event_output_cause_q     [N];
    logic [N-1:0] pend_q;
    logic [N-1:0] chan_reset;
    logic [N-1:0] run_q;

    // Input pins from other domains pass two flops first.
    logic [3:0]  evt_meta_q;
    logic [3:0]  evt_sync_q;
    logic        stby_meta_q;
    logic        stby_sync_q;
    logic [3:0]  bias_meta_q;
    logic [3:0]  bias_sync_q;

    logic        ctrl_reset;
    logic        wr_ch;
    logic [31:0] rdata_d;
    logic [4:0]  low_idx;
    logic        low_any;

    // Synchronisers; first stage feeds only the second.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_meta_q  <= 4'h0;
            evt_sync_q  <= 4'h0;
            stby_meta_q <= 1'b0;
            stby_sync_q <= 1'b0;
            bias_meta_q <= 4'h0;
            bias_sync_q <= 4'h0;
        end else begin
            evt_meta_q  <= event_in_i;
            evt_sync_q  <= evt_meta_q;
            stby_meta_q <= standby_i;
            stby_sync_q <= stby_meta_q;
            bias_meta_q <= ram_back_bias_setting_i;
            bias_sync_q <= bias_meta_q;
        end
    end

    // A write of one to the reset bit of global control resets registers, flags, enables and pending bits, but not synchronisers or run state.
    assign ctrl_reset = write_i && addr_i == dma_irq_pkg::OFF_GLOBAL_CTRL && wdata_i[dma_irq_pkg::BIT_CTRL_RESET];
    assign wr_ch      = write_i;

    // Global registers; the self-clearing reset bit is never stored.
    always_ff @(posedge clk_i) begin
        if (rst_i || ctrl_reset) begin
            global_control_q           <= 16'h0000;
            checksum_control_q         <= 16'h0000;
            checksum_data_input_q      <= 32'h0000_0000;
            checksum_result_q          <= 32'h0000_0000;
            checksum_state_q           <= 8'h00;
            debug_halt_control_q       <= 8'h00;
            service_quality_control_q  <= 8'h00;
            software_trigger_control_q <= 32'h0000_0000;
            priority_control_q         <= 32'h0000_0000;
            ch_sel_q                   <= 4'h0;
        end else if (write_i) begin
            case (addr_i)
                dma_irq_pkg::OFF_GLOBAL_CTRL: global_control_q           <= wdata_i[15:0] & 16'hfffe;
                dma_irq_pkg::OFF_CKSUM_CTRL:  checksum_control_q         <= wdata_i[15:0];
                dma_irq_pkg::OFF_CKSUM_DIN:   checksum_data_input_q      <= wdata_i;
                dma_irq_pkg::OFF_CKSUM_RES:   checksum_result_q          <= wdata_i;
                dma_irq_pkg::OFF_CKSUM_STATE: checksum_state_q           <= wdata_i[7:0];
                dma_irq_pkg::OFF_DBG_HALT:    debug_halt_control_q       <= wdata_i[7:0];
                dma_irq_pkg::OFF_QOS_CTRL:    service_quality_control_q  <= wdata_i[7:0];
                dma_irq_pkg::OFF_SW_TRANSFER_START_ACTION:     software_trigger_control_q <= wdata_i;
                dma_irq_pkg::OFF_PRIO_CTRL:   priority_control_q         <= wdata_i;
                dma_irq_pkg::OFF_CH_SELECT:   ch_sel_q                   <= wdata_i[3:0];
                default: ;
            endcase
        end
    end

    // Per-channel logic, one copy per channel.
    for (genvar c = 0; c < N; c++) begin : g_ch
        logic       sel;
        logic [2:0] set_ev;
        logic [7:0] act;
        logic       evt_any;
        logic       in_en;

        assign sel           = ch_sel_q == 4'(c);
        // Channel reset is the channel reset bit written as one on the selected channel.
        assign chan_reset[c] = wr_ch && sel && addr_i == dma_irq_pkg::OFF_CH_CTRL_A
                               && wdata_i[dma_irq_pkg::BIT_CH_RESET];
        assign set_ev[dma_irq_pkg::BIT_DONE]  = block_done_i[c];
        assign set_ev[dma_irq_pkg::BIT_FAULT] = bus_error_i[c] | bad_descriptor_i[c];
        assign set_ev[dma_irq_pkg::BIT_HALT]  = suspend_enter_i[c];

        // Flags: hardware set beats a software write-one clear on the same cycle.
        always_ff @(posedge clk_i) begin
            if (rst_i || ctrl_reset || chan_reset[c]) begin
                channel_irq_flags_q[c] <= 3'h0;
            end else begin
                channel_irq_flags_q[c] <= set_ev | (channel_irq_flags_q[c] &
                    ~((wr_ch && sel && addr_i == dma_irq_pkg::OFF_IRQ_FLAGS) ? wdata_i[2:0] : 3'h0));
            end
        end

        // Enables: ones in the set register enable, ones in the clear register disable.
        always_ff @(posedge clk_i) begin
            if (rst_i || ctrl_reset || chan_reset[c]) begin
                irq_enable_q[c] <= 3'h0;
            end else if (wr_ch && sel && addr_i == dma_irq_pkg::OFF_IEN_SET) begin
                irq_enable_q[c] <= irq_enable_q[c] | wdata_i[2:0];
            end else if (wr_ch && sel && addr_i == dma_irq_pkg::OFF_IEN_CLEAR) begin
                irq_enable_q[c] <= irq_enable_q[c] & ~wdata_i[2:0];
            end
        end

        // Channel control registers; the reset bit self-clears.
        always_ff @(posedge clk_i) begin
            if (rst_i || ctrl_reset || chan_reset[c]) begin
                channel_control_first_q[c]  <= 8'h00;
                channel_control_second_q[c] <= 8'h00;
                event_output_cause_q[c]     <= 2'h0;
            end else if (wr_ch && sel) begin
                if (addr_i == dma_irq_pkg::OFF_CH_CTRL_A) begin
                    channel_control_first_q[c] <= wdata_i[7:0] & 8'hfe;
                end
                if (addr_i == dma_irq_pkg::OFF_CH_CTRL_B) begin
                    channel_control_second_q[c] <= wdata_i[7:0];
                end
                if (addr_i == dma_irq_pkg::OFF_EVT_CAUSE) begin
                    event_output_cause_q[c] <= wdata_i[1:0];
                end
            end
        end

        // Interrupt request pending for this channel.
        always_ff @(posedge clk_i) begin
            if (rst_i || ctrl_reset || chan_reset[c]) begin
                pend_q[c] <= 1'b0;
            end else begin
                pend_q[c] <= |(channel_irq_flags_q[c] & irq_enable_q[c]);
            end
        end

        // Channel runs unless the device is in standby and the run-in-standby bit is clear.
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                run_q[c] <= 1'b1;
            end else begin
                run_q[c] <= !stby_sync_q || channel_control_first_q[c][dma_irq_pkg::BIT_RUN_STDBY];
            end
        end

        if (c < E) begin : g_evt
            // Event hardware exists only on the low channels.
            assign in_en   = channel_control_second_q[c][dma_irq_pkg::BIT_EVT_IN_EN];
            // Event input line c triggers the enabled action; events still act in standby.
            assign evt_any = evt_sync_q[c];
            dma_evt_action u_act (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .enable_i (in_en),
                .action_i (channel_control_second_q[c][dma_irq_pkg::POS_EVT_ACTION +: 3]),
                .event_i  (evt_any),
                .action_o (act)
            );

            // Output event is registered, so it follows the source pulse one cycle later and lasts as long as it.
            always_ff @(posedge clk_i) begin
                if (rst_i || ctrl_reset || chan_reset[c]) begin
                    event_out_o[c] <= 1'b0;
                end else begin
                    event_out_o[c] <= channel_control_second_q[c][dma_irq_pkg::BIT_EVT_OUT_EN] &&
                        ((event_output_cause_q[c] == dma_irq_pkg::CAUSE_BLOCK && block_done_i[c]) ||
                         (event_output_cause_q[c] == dma_irq_pkg::CAUSE_BEAT && beat_done_i[c]));
                end
            end
        end else begin : g_noevt
            assign act     = 8'h00;
            assign in_en   = 1'b0;
            assign evt_any = 1'b0;
        end

        assign transfer_start_action_o[c]    = act[dma_irq_pkg::ACT_TRANSFER_START_ACTION];
        assign conditional_start_action_o[c] = act[dma_irq_pkg::ACT_CONDITIONAL_START_ACTION];
        assign conditional_block_action_o[c] = act[dma_irq_pkg::ACT_CONDITIONAL_BLOCK_ACTION];
        assign suspend_action_o[c]           = act[dma_irq_pkg::ACT_SUSPEND];
        assign resume_action_o[c]            = act[dma_irq_pkg::ACT_RESUME];
        assign bypass_next_pause_action_o[c] = act[dma_irq_pkg::ACT_BYPASS_NEXT_PAUSE_ACTION];
        assign raise_priority_action_o[c]    = act[dma_irq_pkg::ACT_RAISE_PRIORITY_ACTION];
    end

    // Combined request and wake; registered so the outputs come from flops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o  <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            irq_o  <= |pend_q;
            wake_o <= (|pend_q) && stby_sync_q;
        end
    end

    // Standby RAM access is allowed awake, or asleep with no back bias.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ram_access_ok_o <= 1'b1;
            channel_run_o   <= '1;
        end else begin
            ram_access_ok_o <= !stby_sync_q || bias_sync_q == dma_irq_pkg::RAM_BIAS_NONE;
            channel_run_o   <= run_q;
        end
    end

    // Priority search for the lowest pending channel; the loop runs high to low so the lowest wins.
    always_comb begin
        low_idx = 5'h00;
        low_any = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                low_idx = 5'(i);
                low_any = 1'b1;
            end
        end
    end

    // Read mux; unmapped offsets read zero.
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (addr_i)
            dma_irq_pkg::OFF_GLOBAL_CTRL: rdata_d = {16'h0000, global_control_q};
            dma_irq_pkg::OFF_CKSUM_CTRL:  rdata_d = {16'h0000, checksum_control_q};
            dma_irq_pkg::OFF_CKSUM_DIN:   rdata_d = checksum_data_input_q;
            dma_irq_pkg::OFF_CKSUM_RES:   rdata_d = checksum_result_q;
            dma_irq_pkg::OFF_CKSUM_STATE: rdata_d = {24'h000000, checksum_state_q};
            dma_irq_pkg::OFF_DBG_HALT:    rdata_d = {24'h000000, debug_halt_control_q};
            dma_irq_pkg::OFF_QOS_CTRL:    rdata_d = {24'h000000, service_quality_control_q};
            dma_irq_pkg::OFF_SW_TRANSFER_START_ACTION:     rdata_d = software_trigger_control_q;
            dma_irq_pkg::OFF_PRIO_CTRL:   rdata_d = priority_control_q;
            dma_irq_pkg::OFF_CH_SELECT:   rdata_d = {28'h0000000, ch_sel_q};
            dma_irq_pkg::OFF_LOWEST_PEND: rdata_d = {20'h00000, low_any,
                                                     channel_irq_flags_q[low_idx[3:0]], 3'h0, low_idx};
            dma_irq_pkg::OFF_IRQ_SUMMARY: rdata_d = {16'h0000, pend_q};
            dma_irq_pkg::OFF_STANDBY_CFG: rdata_d = {16'h0000, run_q};
            dma_irq_pkg::OFF_CH_CTRL_A:   rdata_d = {24'h000000, channel_control_first_q[ch_sel_q]};
            dma_irq_pkg::OFF_CH_CTRL_B:   rdata_d = {24'h000000, channel_control_second_q[ch_sel_q]};
            dma_irq_pkg::OFF_EVT_CAUSE:   rdata_d = {30'h0, event_output_cause_q[ch_sel_q]};
            dma_irq_pkg::OFF_IEN_CLEAR,
            dma_irq_pkg::OFF_IEN_SET:     rdata_d = {29'h0, irq_enable_q[ch_sel_q]};
            dma_irq_pkg::OFF_IRQ_FLAGS:   rdata_d = {29'h0, channel_irq_flags_q[ch_sel_q]};
            default:                      rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (read_i) begin
            rdata_o <= rdata_d;
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end
endmodule : dma_channel_irq_event_control

// ---- hdl/dma_evt_action.sv ----
// Per-channel decoder turning an input event into an action strobe one cycle later that lasts as long as the event.
`timescale 1ns/1ps
module dma_evt_action (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       enable_i,
    input  wire logic [2:0] action_i,
    input  wire logic       event_i,
    output logic      [7:0] action_o
);
    // One-hot action strobe, indexed by the action code; code zero means no action.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            action_o <= 8'h00;
        end else if (enable_i && event_i && action_i != dma_irq_pkg::ACT_NONE) begin
            action_o <= 8'h01 << action_i;
        end else begin
            action_o <= 8'h00;
        end
    end
endmodule : dma_evt_action

// ---- hdl/dma_irq_pkg.sv ----
// Package with register map, field positions and encodings for the DMA channel interrupt and event block.
package dma_irq_pkg;
    localparam int          NUM_CH          = 16;
    localparam int          NUM_EVT_CH      = 4;
    localparam int          ADDR_W          = 8;
    // Global register offsets.
    localparam logic [7:0]  OFF_GLOBAL_CTRL = 8'h00;
    localparam logic [7:0]  OFF_CKSUM_CTRL  = 8'h02;
    localparam logic [7:0]  OFF_CKSUM_DIN   = 8'h04;
    localparam logic [7:0]  OFF_CKSUM_RES   = 8'h08;
    localparam logic [7:0]  OFF_CKSUM_STATE = 8'h0c;
    localparam logic [7:0]  OFF_DBG_HALT    = 8'h0d;
    localparam logic [7:0]  OFF_QOS_CTRL    = 8'h0e;
    localparam logic [7:0]  OFF_SW_TRANSFER_START_ACTION     = 8'h10;
    localparam logic [7:0]  OFF_PRIO_CTRL   = 8'h14;
    localparam logic [7:0]  OFF_CH_SELECT   = 8'h1c;
    localparam logic [7:0]  OFF_LOWEST_PEND = 8'h20;
    localparam logic [7:0]  OFF_IRQ_SUMMARY = 8'h24;
    localparam logic [7:0]  OFF_STANDBY_CFG = 8'h28;
    // Per-channel registers, reached through the channel select register.
    localparam logic [7:0]  OFF_CH_CTRL_A   = 8'h40;
    localparam logic [7:0]  OFF_CH_CTRL_B   = 8'h44;
    localparam logic [7:0]  OFF_EVT_CAUSE   = 8'h48;
    localparam logic [7:0]  OFF_IEN_CLEAR   = 8'h4c;
    localparam logic [7:0]  OFF_IEN_SET     = 8'h4d;
    localparam logic [7:0]  OFF_IRQ_FLAGS   = 8'h4e;
    // Flag bit positions.
    localparam int          BIT_FAULT       = 0;
    localparam int          BIT_DONE        = 1;
    localparam int          BIT_HALT        = 2;
    // Channel control fields.
    localparam int          BIT_CH_RESET    = 0;
    localparam int          BIT_RUN_STDBY   = 6;
    localparam int          BIT_EVT_IN_EN   = 3;
    localparam int          BIT_EVT_OUT_EN  = 4;
    localparam int          POS_EVT_ACTION  = 0;
    localparam int          BIT_CTRL_RESET  = 0;
    // Output cause and input action encodings.
    localparam logic [1:0]  CAUSE_BLOCK     = 2'h1;
    localparam logic [1:0]  CAUSE_BEAT      = 2'h3;
    localparam logic [2:0]  ACT_NONE        = 3'h0;
    localparam logic [2:0]  ACT_TRANSFER_START_ACTION        = 3'h1;
    localparam logic [2:0]  ACT_CONDITIONAL_START_ACTION       = 3'h2;
    localparam logic [2:0]  ACT_CONDITIONAL_BLOCK_ACTION      = 3'h3;
    localparam logic [2:0]  ACT_SUSPEND     = 3'h4;
    localparam logic [2:0]  ACT_RESUME      = 3'h5;
    localparam logic [2:0]  ACT_BYPASS_NEXT_PAUSE_ACTION       = 3'h6;
    localparam logic [2:0]  ACT_RAISE_PRIORITY_ACTION      = 3'h7;
    localparam logic [3:0]  RAM_BIAS_NONE   = 4'h0;
endpackage : dma_irq_pkg

// ---- test/dma_channel_irq_event_control_tb.sv ----
// Self-checking testbench for the channel interrupt, event and standby block.
`timescale 1ns/1ps
module dma_channel_irq_event_control_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, write_i = 1'b0, read_i = 1'b0, standby_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o;
    logic [15:0] src [5];
    logic [3:0]  route = 4'h0, ram_back_bias_setting_i = 4'h0, event_in_i, event_out_o;
    logic [15:0] channel_run_o, transfer_start_action_o, conditional_start_action_o, conditional_block_action_o;
    logic [15:0] suspend_action_o, resume_action_o, bypass_next_pause_action_o, raise_priority_action_o;
    logic        irq_o, wake_o, ram_access_ok_o, irq_seen;
    int          n_fail = 0;
    int          cmp_count = 0;
    // Free-running 200 MHz clock.
    always #2.5 clk_i = ~clk_i;
    dma_channel_irq_event_control dma_channel_irq_event_control_i (
        .clk_i, .rst_i, .addr_i, .wdata_i, .write_i, .read_i, .rdata_o,
        .block_done_i(src[0]), .beat_done_i(src[1]), .bus_error_i(src[2]), .bad_descriptor_i(src[3]),
        .suspend_enter_i(src[4]), .event_in_i, .standby_i, .ram_back_bias_setting_i, .irq_o, .wake_o,
        .event_out_o, .channel_run_o, .ram_access_ok_o, .transfer_start_action_o, .conditional_start_action_o,
        .conditional_block_action_o, .suspend_action_o, .resume_action_o, .bypass_next_pause_action_o,
        .raise_priority_action_o
    );
    irq_evt_partner irq_evt_partner_i (
        .clk_i, .rst_i, .irq_i(irq_o), .route_i(route), .event_o(event_in_i), .irq_seen_o(irq_seen)
    );
    // Shared bus cycles and comparisons; expectations always come from the caller.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [15:0] blk = 16'h0);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        src[0]  <= blk;
        @(posedge clk_i);
        write_i <= 1'b0;
        src[0]  <= 16'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clk_i);
        read_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rd
    task automatic pulse(input int k, input int ch);
        @(posedge clk_i);
        src[k][ch] <= 1'b1;
        @(posedge clk_i);
        src[k] <= 16'h0;
    endtask : pulse
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : idle
    // Channel 0 action pulses packed in action-code order.
    function automatic logic [6:0] acts();
        return {raise_priority_action_o[0], bypass_next_pause_action_o[0], resume_action_o[0], suspend_action_o[0],
                conditional_block_action_o[0], conditional_start_action_o[0], transfer_start_action_o[0]};
    endfunction : acts
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    // The tests need well under two thousand cycles, so this only trips on a hang.
    initial begin
        #50000;
        n_fail++;
        finish_test();
    end
    // Main sequence.
    initial begin
        logic [6:0] seen;
        foreach (src[k]) src[k] = 16'h0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        idle(1);
        chk(channel_run_o, 16'hffff);
        rd(dma_irq_pkg::OFF_IRQ_SUMMARY, 32'h0);
        rd(8'h3c, 32'h0);
        $display("test reset done");
        wr(dma_irq_pkg::OFF_CH_SELECT, 32'h5);
        wr(dma_irq_pkg::OFF_IEN_SET, 32'h2);
        rd(dma_irq_pkg::OFF_IEN_CLEAR, 32'h2);
        pulse(0, 5);
        pulse(2, 2);
        idle(4);
        chk(irq_o, 1'b1);
        rd(dma_irq_pkg::OFF_IRQ_SUMMARY, 32'h20);
        rd(dma_irq_pkg::OFF_LOWEST_PEND, 32'ha05);
        wr(dma_irq_pkg::OFF_IEN_CLEAR, 32'h5);
        rd(dma_irq_pkg::OFF_IEN_SET, 32'h2);
        wr(dma_irq_pkg::OFF_IEN_CLEAR, 32'h2);
        idle(4);
        chk(irq_o, 1'b0);
        wr(dma_irq_pkg::OFF_IEN_SET, 32'h2);
        wr(dma_irq_pkg::OFF_IRQ_FLAGS, 32'h2, 16'h0020);
        rd(dma_irq_pkg::OFF_IRQ_FLAGS, 32'h2);
        wr(dma_irq_pkg::OFF_IRQ_FLAGS, 32'h2);
        idle(4);
        chk(irq_o, 1'b0);
        for (int k = 2; k < 5; k++) begin
            pulse(k, 5);
            rd(dma_irq_pkg::OFF_IRQ_FLAGS, (k == 4) ? 32'h4 : 32'h1);
            wr(dma_irq_pkg::OFF_IRQ_FLAGS, 32'h7);
        end
        pulse(0, 5);
        wr(dma_irq_pkg::OFF_CH_CTRL_A, 32'h1);
        idle(4);
        chk(irq_o, 1'b0);
        rd(dma_irq_pkg::OFF_IRQ_FLAGS, 32'h0);
        $display("test interrupts done");
        wr(dma_irq_pkg::OFF_CH_SELECT, 32'h1);
        for (int m = 0; m < 5; m++) begin
            wr(dma_irq_pkg::OFF_CH_CTRL_B, (m < 4) ? 32'h10 : 32'h0);
            wr(dma_irq_pkg::OFF_EVT_CAUSE, m[0] ? dma_irq_pkg::CAUSE_BEAT : dma_irq_pkg::CAUSE_BLOCK);
            pulse(m[1], 1);
            #1;
            chk(event_out_o, (m == 0 || m == 3) ? 4'h2 : 4'h0);
            idle(1);
            chk(event_out_o, 4'h0);
        end
        $display("test output events done");
        wr(dma_irq_pkg::OFF_CH_SELECT, 32'h0);
        for (int c = 0; c < 9; c++) begin
            wr(dma_irq_pkg::OFF_CH_CTRL_B, (c < 8) ? (32'h8 | c) : 32'h7);
            @(posedge clk_i);
            route <= 4'h1;
            @(posedge clk_i);
            route <= 4'h0;
            seen = 7'h0;
            repeat (6) begin
                idle(1);
                seen |= acts();
            end
            chk(seen, (c > 0 && c < 8) ? (32'h1 << (c - 1)) : 32'h0);
        end
        $display("test input events done");
        pulse(4, 0);
        wr(dma_irq_pkg::OFF_CH_SELECT, 32'h3);
        wr(dma_irq_pkg::OFF_CH_CTRL_A, 32'h40);
        wr(dma_irq_pkg::OFF_IEN_SET, 32'h4);
        pulse(4, 3);
        standby_i <= 1'b1;
        idle(6);
        chk(channel_run_o, 16'h0008);
        chk(wake_o, 1'b1);
        chk(irq_seen, 1'b1);
        chk(ram_access_ok_o, 1'b1);
        ram_back_bias_setting_i <= 4'h1;
        idle(6);
        chk(ram_access_ok_o, 1'b0);
        standby_i <= 1'b0;
        ram_back_bias_setting_i <= 4'h0;
        idle(6);
        chk(channel_run_o, 16'hffff);
        chk(wake_o, 1'b0);
        $display("test standby done");
        finish_test();
    end
endmodule : dma_channel_irq_event_control_tb

// ---- test/dma_irq_checker.sv ----
// Checker for the interrupt, event and standby behaviour seen at the block's ports.
`timescale 1ns/1ps
module dma_irq_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        write_i,
    input wire logic        read_i,
    input wire logic [31:0] rdata_o,
    input wire logic [15:0] block_done_i,
    input wire logic [15:0] beat_done_i,
    input wire logic [15:0] bus_error_i,
    input wire logic [15:0] bad_descriptor_i,
    input wire logic [15:0] suspend_enter_i,
    input wire logic [3:0]  event_in_i,
    input wire logic        standby_i,
    input wire logic [3:0]  ram_back_bias_setting_i,
    input wire logic        irq_o,
    input wire logic        wake_o,
    input wire logic [3:0]  event_out_o,
    input wire logic        ram_access_ok_o,
    input wire logic [15:0] transfer_start_action_o,
    input wire logic [15:0] suspend_action_o,
    input wire logic [15:0] raise_priority_action_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Flag sources and three of the seven actions are folded so one assertion covers every channel.
    logic [15:0] set_any;
    logic [15:0] act_any;
    assign set_any = block_done_i | bus_error_i | bad_descriptor_i | suspend_enter_i;
    assign act_any = transfer_start_action_o | suspend_action_o | raise_priority_action_o;
    act_high_zero_a: assert property (act_any[15:4] == 12'h0)
        else $error("action on a channel without events");
    act_cause_a: assert property ((act_any[3:0] & ~$past(event_in_i, 3)) == 4'h0)
        else $error("action without an input event");
    evo_cause_a: assert property ((event_out_o & ~$past(block_done_i[3:0] | beat_done_i[3:0])) == 4'h0)
        else $error("output event without a done pulse");
    wake_src_a: assert property (wake_o |-> irq_o)
        else $error("wake without a pending request");
    rdata_idle_a: assert property (!$past(read_i) |-> rdata_o == 32'h0)
        else $error("read data outside the answer cycle");
    bias_block_a: assert property ((standby_i && ram_back_bias_setting_i != 4'h0) [*5] |-> !ram_access_ok_o)
        else $error("memory access allowed under back bias");
    ram_awake_a: assert property ((!standby_i) [*5] |-> ram_access_ok_o)
        else $error("memory access refused while awake");
    irq_rise_a: assert property ($rose(irq_o) |-> $past(write_i, 3) || $past(set_any, 3) != 16'h0)
        else $error("request rose without a cause");
    irq_fall_a: assert property ($fell(irq_o) |-> $past(write_i, 2) || $past(write_i, 3))
        else $error("request fell without a clear");
    // Main scenarios that the bench must reach.
    irq_seen_c: cover property ($rose(irq_o));
    evo_seen_c: cover property (event_out_o != 4'h0);
    act_seen_c: cover property (act_any != 16'h0);
    wake_seen_c: cover property (wake_o);
endmodule : dma_irq_checker

bind dma_channel_irq_event_control dma_irq_checker dma_irq_checker_i (
    .clk_i, .rst_i, .write_i, .read_i, .rdata_o, .block_done_i, .beat_done_i, .bus_error_i,
    .bad_descriptor_i, .suspend_enter_i, .event_in_i, .standby_i, .ram_back_bias_setting_i, .irq_o,
    .wake_o, .event_out_o, .ram_access_ok_o, .transfer_start_action_o, .suspend_action_o, .raise_priority_action_o
);

// ---- test/irq_evt_partner.sv ----
// Model of the interrupt controller and event routing network around the block.
`timescale 1ns/1ps
module irq_evt_partner (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       irq_i,
    input  wire logic [3:0] route_i,
    output logic      [3:0] event_o,
    output logic            irq_seen_o
);
    // Routing adds one register stage; a routed line idles low like a quiet pin.
    always_ff @(posedge clk_i) begin
        event_o <= rst_i ? 4'h0 : route_i;
    end
    // The interrupt controller remembers any request until reset.
    always_ff @(posedge clk_i) begin
        irq_seen_o <= rst_i ? 1'b0 : (irq_seen_o | irq_i);
    end
endmodule : irq_evt_partner
